// file: hdl/cmp_event_match.sv
// Matches a comparator edge against the selected event mode.
`timescale 1ns/1ps
module cmp_event_match
    import cmp_pkg::*;
(
    input edge_e edge_kind,
    input wire logic [1:0] mode,
    output logic hit
);
    always_comb begin
        case (mode)
            MODE_TOGGLE: hit = (edge_kind != EDGE_IDLE);
            MODE_FALL: hit = (edge_kind == EDGE_FALL);
            MODE_RISE: hit = (edge_kind == EDGE_RISE);
            default: hit = 1'b0;
        endcase
    end
endmodule

// file: hdl/cmp_pkg.sv
// Package with register layout, reset values and types of the comparator control block.
package cmp_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] CSR_OFFSET = 4'h0;
    localparam logic [3:0] PIN_CTRL_OFFSET = 4'h1;
    localparam int BIT_POWER_OFF = 7;
    localparam int BIT_REF_SEL = 6;
    localparam int BIT_RESULT = 5;
    localparam int BIT_FLAG = 4;
    localparam int BIT_IRQ_EN = 3;
    localparam int BIT_CAPTURE = 2;
    localparam int BIT_MODE_HI = 1;
    localparam int BIT_MODE_LO = 0;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [1:0] MODE_TOGGLE = 2'h0;
    localparam logic [1:0] MODE_RESERVED = 2'h1;
    localparam logic [1:0] MODE_FALL = 2'h2;
    localparam logic [1:0] MODE_RISE = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    typedef struct packed {
        logic comparator_power_off;
        logic reference_select;
        logic bandgap_power_on;
    } analog_ctrl_s;

    typedef enum logic [1:0] {
        EDGE_IDLE,
        EDGE_RISE,
        EDGE_FALL
    } edge_e;
endpackage

// file: hdl/cmp_sync.sv
// Two-flop synchroniser with edge detection for the comparator output.
`timescale 1ns/1ps
module cmp_sync
    import cmp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic async_in,
    output logic level,
    output edge_e edge_kind
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic [2:0] fill_q;
    logic edge_ok;

    // The first flop feeds only the second one.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            fill_q <= 3'h0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
            fill_q <= {fill_q[1:0], 1'b1};
        end
    end

    // Edges are held off until prev_q carries a sampled level, so a comparator
    // output that is already high at reset release is not taken as a rising edge.
    assign edge_ok = fill_q[2];
    assign level = sync_q;
    assign edge_kind = !edge_ok ? EDGE_IDLE :
                       (sync_q && !prev_q) ? EDGE_RISE :
                       (!sync_q && prev_q) ? EDGE_FALL : EDGE_IDLE;
endmodule

// file: hdl/comparator_event_control.sv
// Control and status logic around the on-chip voltage comparator.
//
// Behaviour
// - Status bit is one when positive input exceeds negative input, else zero.
// - Bit 7 set powers the comparator off; writable at any time.
// - Bit 6 set feeds bandgap to positive input; clear uses the pin.
// - Bit 5 is read-only and follows the comparator output without a latch.
// - Bit 4 flag sets when an output transition matches the selected mode.
// - Interrupt requested only while flag, local enable and global enable are set.
// - Flag clears automatically when the processor takes the matching vector.
// - Writing one to the flag bit clears it; writing zero keeps it.
// - Bit 2 set routes the comparator output to the timer capture input.
// - Mode bits: 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// - Enabled second serial port takes the shared pins over the direction register.
// - Bandgap reference is powered only while the reference-select bit is one.
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module comparator_event_control
    import cmp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input bus_req_s bus_req,
    output logic [7:0] rdata,
    input wire logic comparator_raw,
    input wire logic global_irq_enable,
    input wire logic irq_ack,
    output logic irq_req,
    output analog_ctrl_s analog_ctrl,
    output logic capture_input,
    output logic capture_route_enable,
    input wire logic second_serial_tx_enable,
    input wire logic second_serial_rx_enable,
    input wire logic second_serial_tx_pin,
    input wire logic [1:0] port_direction_register,
    input wire logic [1:0] port_out,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe
);
    ////////////////////////////////////////////////////////////////////////////
    logic comparator_power_off_q;
    logic reference_select_q;
    logic comparator_event_flag_q;
    logic comparator_irq_enable_q;
    logic capture_route_q;
    logic [1:0] event_mode_q;
    logic [7:0] rdata_q;
    logic comparator_event_flag_d;
    logic comparator_result;
    logic cmp_level;
    edge_e cmp_edge;
    logic event_hit;
    logic csr_sel;
    logic pin_sel;
    logic csr_wr;
    logic flag_clear;
    logic serial_owns;
    logic [7:0] csr_value;
    logic [7:0] rdata_d;

    ////////////////////////////////////////////////////////////////////////////
    cmp_sync u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .async_in(comparator_raw),
        .level(cmp_level),
        .edge_kind(cmp_edge)
    );

    cmp_event_match u_match (
        .edge_kind(cmp_edge),
        .mode(event_mode_q),
        .hit(event_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // A powered-off comparator reads as zero and raises no events.
    assign comparator_result = cmp_level && !comparator_power_off_q;

    assign csr_sel = (bus_req.addr == CSR_OFFSET);
    assign pin_sel = (bus_req.addr == PIN_CTRL_OFFSET);
    assign csr_wr = bus_req.wr && csr_sel;
    assign flag_clear = (csr_wr && bus_req.wdata[BIT_FLAG]) || irq_ack;

    // A new event wins over a clear in the same cycle.
    assign comparator_event_flag_d = (event_hit && !comparator_power_off_q) ? 1'b1 :
                                     flag_clear ? 1'b0 :
                                     comparator_event_flag_q;

    assign csr_value = {comparator_power_off_q, reference_select_q, comparator_result,
                        comparator_event_flag_q, comparator_irq_enable_q, capture_route_q,
                        event_mode_q};

    assign serial_owns = second_serial_tx_enable || second_serial_rx_enable;
    assign rdata_d = !bus_req.rd ? 8'h00 :
                     csr_sel ? csr_value :
                     pin_sel ? {7'h00, serial_owns} : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            comparator_power_off_q <= CSR_RESET[BIT_POWER_OFF];
            reference_select_q <= CSR_RESET[BIT_REF_SEL];
            comparator_irq_enable_q <= CSR_RESET[BIT_IRQ_EN];
            capture_route_q <= CSR_RESET[BIT_CAPTURE];
            event_mode_q <= CSR_RESET[BIT_MODE_HI:BIT_MODE_LO];
        end else if (csr_wr) begin
            comparator_power_off_q <= bus_req.wdata[BIT_POWER_OFF];
            reference_select_q <= bus_req.wdata[BIT_REF_SEL];
            comparator_irq_enable_q <= bus_req.wdata[BIT_IRQ_EN];
            capture_route_q <= bus_req.wdata[BIT_CAPTURE];
            event_mode_q <= bus_req.wdata[BIT_MODE_HI:BIT_MODE_LO];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            comparator_event_flag_q <= CSR_RESET[BIT_FLAG];
            rdata_q <= 8'h00;
        end else begin
            comparator_event_flag_q <= comparator_event_flag_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign rdata = rdata_q;
    assign irq_req = comparator_event_flag_q && comparator_irq_enable_q
                     && global_irq_enable;
    assign analog_ctrl.comparator_power_off = comparator_power_off_q;
    assign analog_ctrl.reference_select = reference_select_q;
    assign analog_ctrl.bandgap_power_on = reference_select_q;
    assign capture_route_enable = capture_route_q;
    assign capture_input = capture_route_q && comparator_result;

    // The serial port drives the plus pin as transmit output and frees the minus
    // pin as receive input, overriding the direction register.
    assign pin_out[0] = second_serial_tx_enable ? second_serial_tx_pin : port_out[0];
    assign pin_oe[0] = serial_owns ? second_serial_tx_enable : port_direction_register[0];
    assign pin_out[1] = port_out[1];
    assign pin_oe[1] = serial_owns ? 1'b0 : port_direction_register[1];
endmodule

// file: sim/analog_front.sv
// Comparator front end model that drives the raw output.
`timescale 1ns/1ps
module analog_front
    import cmp_pkg::*;
#(
    parameter int BANDGAP_MV = 1220
)
(
    input wire logic [11:0] plus_mv,
    input wire logic [11:0] minus_mv,
    input analog_ctrl_s ctrl,
    output logic raw
);
wire [11:0] pos_mv = ctrl.reference_select ? 12'(BANDGAP_MV) : plus_mv;
assign raw = !ctrl.comparator_power_off && pos_mv > minus_mv;
endmodule

// file: sim/cmp_checker_assertions.sv
// Port checker of the comparator control block.
`timescale 1ns/1ps
module cmp_checker
    import cmp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input bus_req_s bus_req,
    input wire logic global_irq_enable,
    input wire logic irq_req,
    input analog_ctrl_s analog_ctrl,
    input wire logic comparator_raw,
    input wire logic capture_input,
    input wire logic capture_route_enable,
    input wire logic second_serial_tx_enable,
    input wire logic second_serial_tx_pin,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe
);
default clocking @(posedge ref_clk); endclocking
default disable iff (srst);
wire csr_wr = bus_req.wr && bus_req.addr == CSR_OFFSET;
wire run = capture_route_enable && !analog_ctrl.comparator_power_off;
property p_pwr; csr_wr |=> analog_ctrl.comparator_power_off == $past(bus_req.wdata[7]); endproperty
a_pwr: assert property (p_pwr) else $error("power bit");
property p_ref; csr_wr |=> analog_ctrl.reference_select == $past(bus_req.wdata[6]); endproperty
a_ref: assert property (p_ref) else $error("reference bit");
property p_rte; csr_wr |=> capture_route_enable == $past(bus_req.wdata[2]); endproperty
a_rte: assert property (p_rte) else $error("route bit");
property p_bg; analog_ctrl.bandgap_power_on == analog_ctrl.reference_select; endproperty
a_bg: assert property (p_bg) else $error("bandgap power");
property p_cap; !capture_route_enable |-> !capture_input; endproperty
a_cap: assert property (p_cap) else $error("capture leak");
property p_irq; irq_req |-> global_irq_enable; endproperty
a_irq: assert property (p_irq) else $error("irq not gated");
property p_sync; (run && comparator_raw) [*4] |-> capture_input; endproperty
a_sync: assert property (p_sync) else $error("capture level");
property p_tx; second_serial_tx_enable |-> pin_oe[0] && pin_out[0] == second_serial_tx_pin; endproperty
a_tx: assert property (p_tx) else $error("serial pin");
endmodule
bind comparator_event_control cmp_checker i_chk (.ref_clk(ref_clk), .srst(srst),
    .bus_req(bus_req), .global_irq_enable(global_irq_enable), .irq_req(irq_req),
    .analog_ctrl(analog_ctrl), .comparator_raw(comparator_raw), .pin_oe(pin_oe),
    .capture_input(capture_input), .capture_route_enable(capture_route_enable),
    .second_serial_tx_enable(second_serial_tx_enable), .pin_out(pin_out),
    .second_serial_tx_pin(second_serial_tx_pin));

// file: sim/tb_top.sv
// Testbench of the comparator control block.
`timescale 1ns/1ps
module tb_top
    import cmp_pkg::*;
;
logic ref_clk = 0, srst = 1, gie = 0, ack = 0, en = 0, rxe = 0, txp = 0, rd_seen = 0, f;
logic [1:0] dir = 0, po = 0, pin_out, pin_oe;
logic [11:0] pv = 0, mv = 2000;
logic [7:0] rdata, w, exp_q[$];
logic raw, irq, cap, cre;
bus_req_s br = '0;
analog_ctrl_s ac;
int n_errors = 0, checked = 0;
always #50 ref_clk = ~ref_clk;
comparator_event_control i_dut (.ref_clk(ref_clk), .srst(srst), .bus_req(br), .rdata(rdata),
    .comparator_raw(raw), .global_irq_enable(gie), .irq_ack(ack), .irq_req(irq),
    .analog_ctrl(ac), .capture_input(cap), .capture_route_enable(cre),
    .second_serial_tx_enable(en), .second_serial_rx_enable(rxe), .second_serial_tx_pin(txp),
    .port_direction_register(dir), .port_out(po), .pin_out(pin_out), .pin_oe(pin_oe));
analog_front i_af (.plus_mv(pv), .minus_mv(mv), .ctrl(ac), .raw(raw));
task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
endtask
task automatic chk(string what, logic [7:0] e, logic [7:0] s);
    checked++;
    if (s !== e) begin
        n_errors++;
        $display("BAD %s expected %h seen %h", what, e, s);
    end
endtask
task automatic op(logic [3:0] a, logic [7:0] d, logic wr, logic rd);
    br <= '{a, d, wr, rd};
    tick(1);
    br <= '0;
    tick(1);
endtask
task automatic rd(logic [3:0] a, logic [7:0] e);
    exp_q.push_back(e);
    op(a, 8'h00, 1'b0, 1'b1);
endtask
task automatic conclude();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
always @(posedge ref_clk) begin
    if (rd_seen)
        chk("rdata", exp_q.pop_front(), rdata);
    rd_seen <= br.rd;
end
initial begin
    tick(5000);
    n_errors++;
    conclude();
end
initial begin
    void'($urandom(32'hD54E));
    tick(16);
    srst <= 0;
    tick(1);
    rd(CSR_OFFSET, CSR_RESET);
    rd(4'h7, 8'h00);
    repeat (4) begin
        w = $urandom;
        op(CSR_OFFSET, w, 1'b1, 1'b0);
        op(4'h7, ~w, 1'b1, 1'b0);
        rd(CSR_OFFSET, w & 8'hCF);
    end
    $display("registers done");
    op(CSR_OFFSET, w & 8'hE7, 1'b1, 1'b0);
    op(CSR_OFFSET, 8'h10, 1'b1, 1'b0);
    mv <= 600;
    for (int m = 0; m < 4; m++) begin
        gie <= m[0];
        op(CSR_OFFSET, {6'h01, m[1:0]}, 1'b1, 1'b0);
        op(CSR_OFFSET, {6'h03, m[1:0]}, 1'b1, 1'b0);
        pv <= 1000;
        tick(6);
        f = m == 0 || m == 3;
        chk("capture", 8'h01, {7'h00, cap});
        chk("irq", {7'h00, f & m[0]}, {7'h00, irq});
        rd(CSR_OFFSET, {3'b001, f, 2'b11, m[1:0]});
        op(CSR_OFFSET, {6'h03, m[1:0]}, 1'b1, 1'b0);
        rd(CSR_OFFSET, {3'b001, f, 2'b11, m[1:0]});
        op(CSR_OFFSET, {6'h07, m[1:0]}, 1'b1, 1'b0);
        rd(CSR_OFFSET, {6'h0B, m[1:0]});
        pv <= 0;
        tick(6);
        f = m == 0 || m == 2;
        rd(CSR_OFFSET, {3'b000, f, 2'b11, m[1:0]});
        ack <= 1;
        tick(1);
        ack <= 0;
        rd(CSR_OFFSET, {6'h03, m[1:0]});
        op(CSR_OFFSET, {6'h01, m[1:0]}, 1'b1, 1'b0);
    end
    $display("events done");
    op(CSR_OFFSET, 8'h44, 1'b1, 1'b0);
    tick(4);
    rd(CSR_OFFSET, 8'h74);
    op(CSR_OFFSET, 8'hD4, 1'b1, 1'b0);
    tick(4);
    chk("capture", 8'h00, {7'h00, cap});
    rd(CSR_OFFSET, 8'hC4);
    $display("reference done");
    repeat (8) begin
        {en, rxe, txp, dir, po} <= 7'($urandom);
        tick(1);
        f = en | rxe;
        chk("pin0", {6'h00, f ? en : dir[0], en ? txp : po[0]},
            {6'h00, pin_oe[0], pin_out[0]});
        chk("pin1", {6'h00, !f & dir[1], po[1]}, {6'h00, pin_oe[1], pin_out[1]});
        rd(PIN_CTRL_OFFSET, {7'h00, f});
    end
    $display("pins done");
    conclude();
end
endmodule
